// ==== design/ssp_pkg.sv ====
// Shared constants and types for the serial peripheral slave port
package ssp_pkg;

    // ==================================================
    // Control and format field positions
    localparam int unsigned MASTER_SEL_BIT  = 0;   // Global control register bit
    localparam int unsigned FMT_PHASE_BIT   = 16;  // Frame format clock phase
    localparam int unsigned FMT_POL_BIT     = 17;  // Frame format clock polarity
    localparam int unsigned FMT_DIV_LSB     = 8;   // Clock divider field low bit
    localparam int unsigned FMT_DIV_MSB     = 15;  // Clock divider field high bit
    localparam int unsigned FMT_WIDTH       = 18;

    // ==================================================
    // Word and timing figures
    localparam int unsigned WORD_BITS       = 16;
    localparam int unsigned CLK_PERIOD_PS   = 8000;   // 125 MHz reference clock
    localparam int unsigned MIN_SCLK_PS     = 25000;  // Least serial clock period, 25 ns
    localparam int unsigned MIN_SCLK_CYC    = (MIN_SCLK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0]  DIV_RESET       = 8'h00;

    // ==================================================
    // Types
    typedef logic [WORD_BITS-1:0] ssp_word_t;
    typedef logic [4:0]           ssp_cnt_t;
    typedef logic [8:0]           ssp_per_t;

    typedef enum logic [2:0]
    {
        SSP_IDLE  = 3'b001,
        SSP_SHIFT = 3'b010,
        SSP_OFF   = 3'b100
    } ssp_state_t;

endpackage // ssp_pkg

// ==== design/ssp_edge_detect.sv ====
// Serial clock edge detector giving both rising and falling edges
module ssp_edge_detect
(
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic sclk,
    output logic      rise,
    output logic      fall
);
    import ssp_pkg::*;

    logic sclk_q;
    logic sclk_d;
    logic seen_q;
    logic seen_d;

    // ==================================================
    // Previous level of the serial clock
    always_comb
    begin
        sclk_d = sclk;
        seen_d = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sclk_q <= 1'b0;
            seen_q <= 1'b0;
        end
        else
        begin
            sclk_q <= sclk_d;
            seen_q <= seen_d;
        end
    end

    // Edges flagged at once from the live pin against the registered level, inputs taken as synchronous
    // Masked until one real level is held: the reset level may not match the pin
    assign rise = seen_q & sclk & ~sclk_q;
    assign fall = seen_q & ~sclk & sclk_q;

endmodule // ssp_edge_detect

// ==== design/ssp_slave_port.sv ====
// Serial peripheral port in slave mode, sixteen-bit framed words
module ssp_slave_port
(
    input  wire logic                        ref_clk,
    input  wire logic                        resetn,
    input  wire logic [31:0]                 global_control_register,
    input  wire logic [ssp_pkg::FMT_WIDTH-1:0] frame_format_register,
    input  wire logic                        chip_select_n,
    input  wire logic                        serial_shift_clock,
    input  wire logic                        peripheral_data_in,
    output logic                             peripheral_data_out,
    output logic                             data_out_oe_n,
    input  wire ssp_pkg::ssp_word_t          tx_word,
    output logic                             tx_load,
    output ssp_pkg::ssp_word_t               rx_word,
    output logic                             rx_valid,
    output logic                             rate_error
);
    import ssp_pkg::*;

    // ==================================================
    // Mode decode
    logic slave_en;
    logic pha;
    logic pol;
    logic mode_same;
    logic launch_edge;
    logic sample_edge;
    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] div_fld;
    ssp_per_t   min_per;

    assign slave_en  = ~global_control_register[MASTER_SEL_BIT];
    assign pha       = frame_format_register[FMT_PHASE_BIT];
    assign pol       = frame_format_register[FMT_POL_BIT];
    assign div_fld   = frame_format_register[FMT_DIV_MSB:FMT_DIV_LSB];
    assign mode_same = (pol == pha);
    // Launch and sample on opposite edges
    assign launch_edge = mode_same ? sclk_rise : sclk_fall;
    assign sample_edge = mode_same ? sclk_fall : sclk_rise;

    // Least legal period in reference cycles, also never below 25 ns
    always_comb
    begin
        if (div_fld == 8'h00)
        begin
            min_per = 9'h002;
        end
        else
        begin
            min_per = {1'b0, div_fld} + 9'h001;
        end
        if (min_per < 9'(MIN_SCLK_CYC))
        begin
            min_per = 9'(MIN_SCLK_CYC);
        end
    end

    ssp_edge_detect u_edge
    (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .sclk    (serial_shift_clock),
        .rise    (sclk_rise),
        .fall    (sclk_fall)
    );

    // ==================================================
    // Frame state
    ssp_state_t state_q, state_d;
    ssp_word_t  rx_sh_q, rx_sh_d;
    ssp_word_t  tx_sh_q, tx_sh_d;
    ssp_cnt_t   bits_q, bits_d;
    ssp_per_t   per_q, per_d;
    ssp_word_t  rx_word_d;
    logic       rx_valid_d;
    logic       tx_load_d;
    logic       dout_q, dout_d;
    logic       oe_n_q, oe_n_d;
    logic       rate_err_q, rate_err_d;
    logic       first_q, first_d;

    // Next-state logic; the period counter measures between sample edges
    always_comb
    begin
        state_d    = state_q;
        rx_sh_d    = rx_sh_q;
        tx_sh_d    = tx_sh_q;
        bits_d     = bits_q;
        per_d      = (per_q == 9'h1ff) ? per_q : per_q + 9'h001;
        rx_word_d  = rx_word;
        rx_valid_d = 1'b0;
        tx_load_d  = 1'b0;
        dout_d     = dout_q;
        oe_n_d     = oe_n_q;
        rate_err_d = rate_err_q;
        first_d    = first_q;
        case (state_q)
            SSP_OFF:
            begin
                oe_n_d = 1'b1;
                if (slave_en)
                begin
                    state_d = SSP_IDLE;
                end
            end
            SSP_IDLE:
            begin
                oe_n_d = 1'b1;
                if (!slave_en)
                begin
                    state_d = SSP_OFF;
                end
                else if (!chip_select_n)
                begin
                    // Phase 0 puts the first bit out before any clock edge
                    state_d    = SSP_SHIFT;
                    bits_d     = 5'h00;
                    oe_n_d     = 1'b0;
                    dout_d     = tx_sh_q[WORD_BITS-1];
                    tx_sh_d    = pha ? tx_sh_q : {tx_sh_q[WORD_BITS-2:0], 1'b0};
                    first_d    = 1'b1;
                    rate_err_d = 1'b0;
                end
            end
            SSP_SHIFT:
            begin
                if (chip_select_n)
                begin
                    // Word handed over at deselect; a short frame is dropped
                    state_d   = SSP_IDLE;
                    oe_n_d    = 1'b1;
                    tx_sh_d   = tx_word;
                    tx_load_d = 1'b1;
                    if (bits_q == 5'(WORD_BITS))
                    begin
                        rx_word_d  = rx_sh_q;
                        rx_valid_d = 1'b1;
                    end
                end
                else
                begin
                    if (sample_edge && bits_q < 5'(WORD_BITS))
                    begin
                        rx_sh_d = {rx_sh_q[WORD_BITS-2:0], peripheral_data_in};
                        bits_d  = bits_q + 5'h01;
                        per_d   = 9'h001;
                        if (!first_q && per_q < min_per)
                        begin
                            rate_err_d = 1'b1;
                        end
                        first_d = 1'b0;
                    end
                    // Phase 1 launches on the first edge; phase 0 already did
                    if (launch_edge && (pha || !first_q || bits_q != 5'h00))
                    begin
                        dout_d  = tx_sh_q[WORD_BITS-1];
                        tx_sh_d = {tx_sh_q[WORD_BITS-2:0], 1'b0};
                    end
                    // Master select mid-frame abandons the frame and frees the line
                    if (!slave_en)
                    begin
                        state_d = SSP_OFF;
                        oe_n_d  = 1'b1;
                    end
                end
            end
            default:
            begin
                state_d = SSP_OFF;
            end
        endcase
    end

    // State registers
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q     <= SSP_OFF;
            rx_sh_q     <= '0;
            tx_sh_q     <= '0;
            bits_q      <= '0;
            per_q       <= '0;
            rx_word     <= '0;
            rx_valid    <= 1'b0;
            tx_load     <= 1'b0;
            dout_q      <= 1'b0;
            oe_n_q      <= 1'b1;
            rate_err_q  <= 1'b0;
            first_q     <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            rx_sh_q     <= rx_sh_d;
            tx_sh_q     <= tx_sh_d;
            bits_q      <= bits_d;
            per_q       <= per_d;
            rx_word     <= rx_word_d;
            rx_valid    <= rx_valid_d;
            tx_load     <= tx_load_d;
            dout_q      <= dout_d;
            oe_n_q      <= oe_n_d;
            rate_err_q  <= rate_err_d;
            first_q     <= first_d;
        end
    end

    assign peripheral_data_out = dout_q;
    assign data_out_oe_n       = oe_n_q;
    assign rate_error          = rate_err_q;

    // ==================================================
    // Checks
    sequence s_frame_end;
        state_q == SSP_SHIFT && chip_select_n && bits_q == 5'(WORD_BITS);
    endsequence

    a_word_handover: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_frame_end |=> rx_valid && tx_load)
        else $error("full frame not handed over");
    a_master_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
        global_control_register[MASTER_SEL_BIT] |-> ##2 data_out_oe_n)
        else $error("data out driven in master mode");
    a_sample_shift: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_q == SSP_SHIFT && !chip_select_n && sample_edge && bits_q < 5'(WORD_BITS))
        |=> rx_sh_q[0] == $past(peripheral_data_in))
        else $error("data in not sampled on active edge");
    a_launch_bit: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_q == SSP_SHIFT && !chip_select_n && launch_edge && !first_q)
        |=> peripheral_data_out == $past(tx_sh_q[WORD_BITS-1]))
        else $error("data out not launched on edge");
    a_phase_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_q == SSP_IDLE && slave_en && !chip_select_n && !pha)
        |=> !data_out_oe_n && peripheral_data_out == $past(tx_sh_q[WORD_BITS-1]))
        else $error("phase 0 first bit missing");
    a_pol_edge: assert property (@(posedge ref_clk) disable iff (!resetn)
        sample_edge |-> serial_shift_clock == (pol ^ pha))
        else $error("polarity edge choice wrong");
    a_rate_floor: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_q == SSP_SHIFT && !chip_select_n && sample_edge && bits_q < 5'(WORD_BITS) && !first_q
         && (per_q < 9'(MIN_SCLK_CYC) || (div_fld != 8'h00 && per_q <= {1'b0, div_fld})))
        |=> rate_error)
        else $error("too fast serial clock not flagged");
    a_input_dirs: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_q == SSP_SHIFT && !chip_select_n) |-> !data_out_oe_n)
        else $error("data out not driven in frame");

endmodule // ssp_slave_port

// ==== tb/ssp_host_model.sv ====
// Behavioural host master that frames sixteen-bit words into the slave port
module ssp_host_model import ssp_pkg::*;
(
    input  wire logic ref_clk,
    output logic      chip_select_n,
    output logic      serial_shift_clock,
    output logic      peripheral_data_in,
    input  wire logic peripheral_data_out,
    input  wire logic data_out_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic flip_q = 1'b0;
    logic miso;

    // ==================================================
    // Released data line
    // A released line toggles each cycle so a stale bit never passes for data
    always @(posedge ref_clk)
        flip_q <= ~flip_q;
    assign miso = data_out_oe_n ? flip_q : peripheral_data_out;

    initial
    begin
        chip_select_n      = 1'b1;
        serial_shift_clock = 1'b1;
        peripheral_data_in = 1'b0;
    end

    // ==================================================
    // One frame; half is the serial half period in clock cycles
    task automatic xfer(input ssp_word_t tx, input logic pol, input logic pha, input int half,
                        input int nbits, output ssp_word_t rx);
        int   e;
        int   bit_i;
        logic smp;
        rx    = '0;
        bit_i = WORD_BITS - 1;
        @(posedge ref_clk);
        serial_shift_clock <= ~pol;
        repeat (2) @(posedge ref_clk);
        chip_select_n      <= 1'b0;
        peripheral_data_in <= tx[bit_i];
        repeat (4 * half) @(posedge ref_clk);
        for (e = 0; e < 2 * nbits; e++)
        begin
            // Phase 0 samples on the first edge, phase 1 launches on it
            smp = ((e % 2) == 0) ^ pha;
            serial_shift_clock <= ~serial_shift_clock;
            if (smp)
            begin
                rx = {rx[WORD_BITS-2:0], miso};
                bit_i--;
            end
            else if (e > 0 && bit_i >= 0)
                peripheral_data_in <= tx[bit_i];
            repeat (half) @(posedge ref_clk);
        end
        chip_select_n      <= 1'b1;
        peripheral_data_in <= ~peripheral_data_in;
    endtask
endmodule // ssp_host_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the slave port driven by the host master model
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top import ssp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  ref_clk = 1'b0;
    logic                  resetn  = 1'b0;
    logic [31:0]           gcr     = 32'h0000_0000;
    logic [FMT_WIDTH-1:0]  fmt     = '0;
    logic                  cs_n;
    logic                  sclk;
    logic                  mosi;
    logic                  dout;
    logic                  oe_n;
    ssp_word_t             tx_word = 16'h0000;
    logic                  tx_load;
    ssp_word_t             rx_word;
    logic                  rx_valid;
    logic                  rate_error;
    ssp_word_t             got;
    ssp_word_t             exp_tx  = 16'h0000;
    ssp_word_t             words[5] = '{16'h8001, 16'ha5c3, 16'h3c96, 16'h7ffe, 16'h0ff0};
    int                    errors  = 0;
    int                    compares = 0;
    int                    rx_cnt  = 0;
    int                    ld_cnt  = 0;
    int                    oe_cnt  = 0;
    int                    m;
    int                    save;
    logic [1:0]            md;

    always #4 ref_clk = ~ref_clk;

    ssp_slave_port i_ssp_slave_port (.ref_clk(ref_clk), .resetn(resetn), .global_control_register(gcr),
        .frame_format_register(fmt), .chip_select_n(cs_n), .serial_shift_clock(sclk),
        .peripheral_data_in(mosi), .peripheral_data_out(dout), .data_out_oe_n(oe_n),
        .tx_word(tx_word), .tx_load(tx_load), .rx_word(rx_word), .rx_valid(rx_valid),
        .rate_error(rate_error));

    ssp_host_model i_ssp_host_model (.ref_clk(ref_clk), .chip_select_n(cs_n), .serial_shift_clock(sclk),
        .peripheral_data_in(mosi), .peripheral_data_out(dout), .data_out_oe_n(oe_n));

    // ==================================================
    // Pulse and drive counters, one cycle pulses seen where they stand
    always @(posedge ref_clk)
    begin
        rx_cnt <= rx_cnt + (rx_valid === 1'b1);
        ld_cnt <= ld_cnt + (tx_load === 1'b1);
        oe_cnt <= oe_cnt + (oe_n === 1'b0);
    end

    task automatic stop_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Frame with settle time, then the line must be released again
    task automatic run(input ssp_word_t hw, input logic [1:0] mode, input int nbits);
        i_ssp_host_model.xfer(hw, mode[1], mode[0], 3, nbits, got);
        repeat (3) @(posedge ref_clk);
    endtask

    // ==================================================
    // Tests
    initial
    begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        // All four polarity and phase settings back to back
        for (m = 0; m < 4; m++)
        begin
            md = m[1:0];
            fmt     <= {md, 8'h03, 8'h00};
            tx_word <= words[m + 1];
            run(~words[m], md, 16);
            `CHK(got, exp_tx)
            `CHK(rx_word, ~words[m])
            `CHK(rx_cnt, m + 1)
            `CHK(ld_cnt, m + 1)
            `CHK(oe_n, 1'b1)
            exp_tx = words[m + 1];
        end
        `CHK(oe_cnt > 0, 1'b1)
        $display("test modes done");
        // Fifteen-bit frame gives no word but still reloads
        fmt     <= {2'b00, 8'h03, 8'h00};
        tx_word <= 16'h1e2d;
        run(16'h1234, 2'b00, 15);
        `CHK(rx_cnt, 4)
        `CHK(rx_word, ~words[3])
        `CHK(ld_cnt, 5)
        exp_tx = 16'h1e2d;
        $display("test short frame done");
        // Divider nine needs ten cycles, six is too fast
        fmt     <= {2'b00, 8'h09, 8'h00};
        tx_word <= 16'h5a5a;
        run(16'h00ff, 2'b00, 16);
        `CHK(rate_error, 1'b1)
        `CHK(got, exp_tx)
        exp_tx = 16'h5a5a;
        fmt <= {2'b00, 8'h00, 8'h00};
        run(16'hf00f, 2'b00, 16);
        `CHK(rate_error, 1'b0)
        `CHK(got, exp_tx)
        `CHK(rx_word, 16'hf00f)
        // Six cycles meets divider five exactly, divider six wants seven
        fmt <= {2'b00, 8'h05, 8'h00};
        run(16'h0f0f, 2'b00, 16);
        `CHK(rate_error, 1'b0)
        `CHK(got, exp_tx)
        fmt <= {2'b00, 8'h06, 8'h00};
        run(16'hc33c, 2'b00, 16);
        `CHK(rate_error, 1'b1)
        `CHK(rx_word, 16'hc33c)
        $display("test rate done");
        // Master select set: port stays silent
        gcr <= 32'h0000_0001;
        repeat (2) @(posedge ref_clk);
        save = rx_cnt;
        m    = oe_cnt;
        run(16'h4321, 2'b00, 16);
        `CHK(rx_cnt, save)
        `CHK(oe_cnt, m)
        $display("test master select done");
        stop_test();
    end

    // Frames take near 115 cycles each, so this is far beyond the run
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end
endmodule // tb_top
